/* shared/sfrwg_consts.svh */
// Purpose: offsets, bit positions, reset values of the sfr write guard block
// Assumes: sfr addresses are 8 bits, privileged page shares the address space
// Notes:   definitions only
`ifndef SFRWG_CONSTS_SVH
`define SFRWG_CONSTS_SVH

// privileged page registers
`define SFRWG_ADDR_GUARD        8'h48
`define SFRWG_ADDR_DEVCTL       8'h4c
// guarded registers, same address on every page
`define SFRWG_ADDR_POWER_FIRST  8'h87
`define SFRWG_ADDR_POWER_SECOND 8'h97
`define SFRWG_ADDR_CLOCK_FIRST  8'hc7
`define SFRWG_ADDR_WATCHDOG     8'he1
`define SFRWG_ADDR_PORT_FOUR    8'he8
`define SFRWG_ADDR_PORT_SIX     8'hf8

// guard bit positions
`define SFRWG_BIT_POWER_ZERO_GUARD 0
`define SFRWG_BIT_POWER_ONE_GUARD  1
`define SFRWG_BIT_CLOCK_REG_GUARD  2
`define SFRWG_BIT_WATCHDOG_GUARD   4
`define SFRWG_BIT_PORT_FOUR_GUARD  5
`define SFRWG_BIT_PORT_SIX_GUARD   6

// device control bit positions
`define SFRWG_BIT_HIGH_SPEED       7
`define SFRWG_BIT_APP_DATA_ONLY    6
`define SFRWG_BIT_ULTRA_SPEED      5
`define SFRWG_BIT_PORT_RESET_SCOPE 2
`define SFRWG_BIT_RESET_PIN_SEL    1
`define SFRWG_BIT_DEBUG_EN         0
`define SFRWG_DEVCTL_RD_MASK       8'he7

// reset values
`define SFRWG_RST_GUARD        8'h00
`define SFRWG_RST_DEVCTL       8'h83
`define SFRWG_RST_POWER_FIRST  8'h10
`define SFRWG_RST_POWER_SECOND 8'h00
`define SFRWG_RST_CLOCK_FIRST  8'h00
`define SFRWG_RST_WATCHDOG     8'h00
`define SFRWG_RST_PORT_FOUR    8'hff
`define SFRWG_RST_PORT_SIX     8'hff

`endif

/* shared/sfrwg_pkg.sv */
// Purpose: shared types of the sfr write guard block
// Assumes: nothing
// Notes:   constants live in sfrwg_consts.svh
package sfrwg_pkg;
   typedef logic [7:0] sfrwg_byte_t;
   // index of each guarded register in the target array
   typedef enum logic [2:0] {
      SFRWG_G_POWER_FIRST,
      SFRWG_G_POWER_SECOND,
      SFRWG_G_CLOCK_FIRST,
      SFRWG_G_WATCHDOG,
      SFRWG_G_PORT_FOUR,
      SFRWG_G_PORT_SIX
   } sfrwg_gidx_t;
   localparam int SFRWG_NGUARD = 6;
endpackage : sfrwg_pkg

/* shared/sfrwg_dec_if.sv */
// Purpose: decoded strobes from the address decoder to the register bank
// Assumes: one clock, strobes are combinational within the cycle
// Notes:   g_* bits are indexed by sfrwg_pkg::sfrwg_gidx_t
`timescale 1ns/10ps
`default_nettype none
interface sfrwg_dec_if;
   logic [5:0] g_hit;
   logic [5:0] g_we;
   logic       guard_hit;
   logic       guard_we;
   logic       devctl_hit;
   logic       devctl_we;
   modport src (output g_hit, output g_we, output guard_hit, output guard_we,
                output devctl_hit, output devctl_we);
   modport dst (input g_hit, input g_we, input guard_hit, input guard_we,
                input devctl_hit, input devctl_we);
endinterface : sfrwg_dec_if
`default_nettype wire

/* rtl/sfrwg_decode.sv */
// Purpose: address decode and write gating for guarded sfrs
// Assumes: i_guard comes from the register bank on the same clock
// Notes:   purely combinational
`timescale 1ns/10ps
`default_nettype none
`include "sfrwg_consts.svh"
module sfrwg_decode (
   input  wire logic [7:0] i_sfr_addr,
   input  wire logic       i_sfr_page_p,
   input  wire logic       i_sfr_wr,
   input  wire logic [7:0] i_guard,
   sfrwg_dec_if.src        dec
);
   function automatic logic [2:0] guard_pos(input int idx);
      unique case (idx)
         0:       guard_pos = 3'(`SFRWG_BIT_POWER_ZERO_GUARD);
         1:       guard_pos = 3'(`SFRWG_BIT_POWER_ONE_GUARD);
         2:       guard_pos = 3'(`SFRWG_BIT_CLOCK_REG_GUARD);
         3:       guard_pos = 3'(`SFRWG_BIT_WATCHDOG_GUARD);
         4:       guard_pos = 3'(`SFRWG_BIT_PORT_FOUR_GUARD);
         default: guard_pos = 3'(`SFRWG_BIT_PORT_SIX_GUARD);
      endcase
   endfunction : guard_pos

   function automatic logic [7:0] g_addr(input int idx);
      unique case (idx)
         0:       g_addr = `SFRWG_ADDR_POWER_FIRST;
         1:       g_addr = `SFRWG_ADDR_POWER_SECOND;
         2:       g_addr = `SFRWG_ADDR_CLOCK_FIRST;
         3:       g_addr = `SFRWG_ADDR_WATCHDOG;
         4:       g_addr = `SFRWG_ADDR_PORT_FOUR;
         default: g_addr = `SFRWG_ADDR_PORT_SIX;
      endcase
   endfunction : g_addr

   always_comb begin
      for (int i = 0; i < sfrwg_pkg::SFRWG_NGUARD; i++) begin
         dec.g_hit[i] = (i_sfr_addr == g_addr(i));
         // privileged page always writes; ordinary page only when unguarded
         dec.g_we[i]  = i_sfr_wr && dec.g_hit[i] &&
                        (i_sfr_page_p || !i_guard[guard_pos(i)]);
      end
      dec.guard_hit  = i_sfr_page_p && (i_sfr_addr == `SFRWG_ADDR_GUARD);
      dec.guard_we   = i_sfr_wr && dec.guard_hit;
      dec.devctl_hit = i_sfr_page_p && (i_sfr_addr == `SFRWG_ADDR_DEVCTL);
      dec.devctl_we  = i_sfr_wr && dec.devctl_hit;
   end
endmodule : sfrwg_decode
`default_nettype wire

/* rtl/sfrwg_top.sv */
// Purpose: sfr write guard and device control registers with guarded targets
// Assumes: sfr bus from the core on i_mclk; i_hard_rst qualifies i_rst_b
// Notes:   read data appears one clock after i_sfr_rd
//          blocked writes vanish without a flag; software cannot see them
//          port six may outlive soft resets, so its value after reset is not fixed
//          strobes are ignored while reset is low
//
// Summary of operation
// - port-six guard set: ordinary-page writes to port six latch ignored, reads work.
// - port-four guard set: ordinary-page writes to port four latch ignored.
// - watchdog guard set: watchdog control read-only from ordinary pages.
// - clock guard set: first clock control read-only from ordinary pages.
// - power-one guard set: second power control read-only from ordinary pages.
// - power-zero guard set: first power control read-only from ordinary pages.
// - privileged page always writes every guarded register.
// - high-speed clear means low-power mode, clock up to 6MHz.
// - data-only bit blocks instruction fetch from in-app flash region.
// - ultra-speed bit enables clock above 25MHz, needs high-speed too.
// - scope bit set: port six reset only by hard reset events.
// - reset pin select routes pad to reset input when set.
// - debug enable connects debug interface to its port-four pins.
`timescale 1ns/10ps
`default_nettype none
`include "sfrwg_consts.svh"
module sfrwg_top (
   input  wire logic       i_mclk,
   input  wire logic       i_rst_b,
   input  wire logic       i_hard_rst,
   input  wire logic [7:0] i_sfr_addr,
   input  wire logic       i_sfr_page_p,
   input  wire logic       i_sfr_wr,
   input  wire logic       i_sfr_rd,
   input  wire logic [7:0] i_sfr_wdata,
   output logic      [7:0] o_sfr_rdata,
   output logic      [7:0] o_guard,
   output logic      [7:0] o_power_first,
   output logic      [7:0] o_power_second,
   output logic      [7:0] o_clock_first,
   output logic      [7:0] o_watchdog_ctrl,
   output logic      [7:0] o_port_four,
   output logic      [7:0] o_port_six,
   output logic            o_low_power_mode,
   output logic            o_ultra_speed_en,
   output logic            o_app_exec_en,
   output logic            o_port_reset_scope,
   output logic            o_reset_pin_sel,
   output logic            o_debug_en
);
   localparam int NG = sfrwg_pkg::SFRWG_NGUARD;

   sfrwg_dec_if dec ();

   sfrwg_pkg::sfrwg_byte_t guard_r;
   sfrwg_pkg::sfrwg_byte_t guard_nxt;
   sfrwg_pkg::sfrwg_byte_t devctl_r;
   sfrwg_pkg::sfrwg_byte_t devctl_nxt;
   // one byte per guarded register, indexed by sfrwg_gidx_t
   sfrwg_pkg::sfrwg_byte_t greg_r   [NG];
   sfrwg_pkg::sfrwg_byte_t greg_nxt [NG];
   sfrwg_pkg::sfrwg_byte_t rdata_r;
   sfrwg_pkg::sfrwg_byte_t rdata_nxt;
   logic                   low_power_r;
   logic                   low_power_nxt;
   logic                   ultra_r;
   logic                   ultra_nxt;
   logic                   app_exec_r;
   logic                   app_exec_nxt;

   sfrwg_decode u_decode (
      .i_sfr_addr   (i_sfr_addr),
      .i_sfr_page_p (i_sfr_page_p),
      .i_sfr_wr     (i_sfr_wr),
      .i_guard      (guard_r),
      .dec          (dec)
   );

   function automatic sfrwg_pkg::sfrwg_byte_t greg_rst(input int idx);
      unique case (idx)
         0:       greg_rst = `SFRWG_RST_POWER_FIRST;
         1:       greg_rst = `SFRWG_RST_POWER_SECOND;
         2:       greg_rst = `SFRWG_RST_CLOCK_FIRST;
         3:       greg_rst = `SFRWG_RST_WATCHDOG;
         4:       greg_rst = `SFRWG_RST_PORT_FOUR;
         default: greg_rst = `SFRWG_RST_PORT_SIX;
      endcase
   endfunction : greg_rst

   // guard register: written only through the privileged page
   always_comb begin
      guard_nxt = guard_r;
      // top bit is stored as written; software keeps it zero
      if (dec.guard_we) begin
         guard_nxt = i_sfr_wdata;
      end
      if (!i_rst_b) begin
         guard_nxt = `SFRWG_RST_GUARD;
      end
   end

   always_ff @(posedge i_mclk) begin
      guard_r <= guard_nxt;
   end

   // stored bits four and three are masked out of every read
   function automatic sfrwg_pkg::sfrwg_byte_t devctl_view(input sfrwg_pkg::sfrwg_byte_t v);
      devctl_view = v & `SFRWG_DEVCTL_RD_MASK;
   endfunction : devctl_view

   // device control register
   always_comb begin
      devctl_nxt = devctl_r;
      if (dec.devctl_we) begin
         devctl_nxt = i_sfr_wdata;
      end
      if (!i_rst_b) begin
         devctl_nxt = `SFRWG_RST_DEVCTL;
         // scope bit survives soft resets so it can protect port six
         if (!i_hard_rst) begin
            devctl_nxt[`SFRWG_BIT_PORT_RESET_SCOPE] = devctl_r[`SFRWG_BIT_PORT_RESET_SCOPE];
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      devctl_r <= devctl_nxt;
   end

   // hard resets always clear port six; soft ones only while the scope bit is clear
   function automatic logic port_six_cleared(input logic hard, input logic scope);
      port_six_cleared = hard || !scope;
   endfunction : port_six_cleared

   // guarded targets; a refused write just leaves the value, nothing else moves
   always_comb begin
      for (int i = 0; i < NG; i++) begin
         greg_nxt[i] = greg_r[i];
         if (dec.g_we[i]) begin
            greg_nxt[i] = i_sfr_wdata;
         end
      end
      if (!i_rst_b) begin
         for (int i = 0; i < NG - 1; i++) begin
            greg_nxt[i] = greg_rst(i);
         end
         // no write may slip into a port six that a soft reset keeps
         greg_nxt[sfrwg_pkg::SFRWG_G_PORT_SIX] = greg_r[sfrwg_pkg::SFRWG_G_PORT_SIX];
         if (port_six_cleared(i_hard_rst, devctl_r[`SFRWG_BIT_PORT_RESET_SCOPE])) begin
            greg_nxt[sfrwg_pkg::SFRWG_G_PORT_SIX] = `SFRWG_RST_PORT_SIX;
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      greg_r <= greg_nxt;
   end

   // derived control levels, registered so every output is a flop
   always_comb begin
      low_power_nxt = !devctl_nxt[`SFRWG_BIT_HIGH_SPEED];
      // ultra speed only takes effect together with high speed
      ultra_nxt     = devctl_nxt[`SFRWG_BIT_ULTRA_SPEED] && devctl_nxt[`SFRWG_BIT_HIGH_SPEED];
      app_exec_nxt  = !devctl_nxt[`SFRWG_BIT_APP_DATA_ONLY];
   end

   // derived levels move at the same edge as device control
   always_ff @(posedge i_mclk) begin
      low_power_r <= low_power_nxt;
      ultra_r     <= ultra_nxt;
      app_exec_r  <= app_exec_nxt;
   end

   // read path; unmapped addresses read zero
   // a read beside a write in one cycle returns the old value
   always_comb begin
      rdata_nxt = rdata_r;
      if (i_sfr_rd) begin
         rdata_nxt = 8'h00;
         for (int i = 0; i < NG; i++) begin
            if (dec.g_hit[i]) begin
               rdata_nxt = greg_r[i];
            end
         end
         if (dec.guard_hit) begin
            rdata_nxt = guard_r;
         end
         // reserved bits four and three read as zero
         if (dec.devctl_hit) begin
            rdata_nxt = devctl_view(devctl_r);
         end
      end
      if (!i_rst_b) begin
         rdata_nxt = 8'h00;
      end
   end

   always_ff @(posedge i_mclk) begin
      rdata_r <= rdata_nxt;
   end

   always_comb begin
      o_sfr_rdata        = rdata_r;
      o_guard            = guard_r;
      o_power_first      = greg_r[sfrwg_pkg::SFRWG_G_POWER_FIRST];
      o_power_second     = greg_r[sfrwg_pkg::SFRWG_G_POWER_SECOND];
      o_clock_first      = greg_r[sfrwg_pkg::SFRWG_G_CLOCK_FIRST];
      o_watchdog_ctrl    = greg_r[sfrwg_pkg::SFRWG_G_WATCHDOG];
      o_port_four        = greg_r[sfrwg_pkg::SFRWG_G_PORT_FOUR];
      o_port_six         = greg_r[sfrwg_pkg::SFRWG_G_PORT_SIX];
      o_low_power_mode   = low_power_r;
      o_ultra_speed_en   = ultra_r;
      o_app_exec_en      = app_exec_r;
      o_port_reset_scope = devctl_r[`SFRWG_BIT_PORT_RESET_SCOPE];
      o_reset_pin_sel    = devctl_r[`SFRWG_BIT_RESET_PIN_SEL];
      o_debug_en         = devctl_r[`SFRWG_BIT_DEBUG_EN];
   end
endmodule : sfrwg_top
`default_nettype wire

/* tb/sfrwg_checker.sv */
// Purpose: port-level checks of the sfr write guard block
// Assumes: single clock, synchronous active-low reset
// Notes:   bound to sfrwg_top at the foot
`timescale 1ns/10ps
`default_nettype none
`include "sfrwg_consts.svh"
module sfrwg_checker (
   input wire logic       i_mclk,
   input wire logic       i_rst_b,
   input wire logic       i_hard_rst,
   input wire logic [7:0] i_sfr_addr,
   input wire logic       i_sfr_page_p,
   input wire logic       i_sfr_wr,
   input wire logic       i_sfr_rd,
   input wire logic [7:0] i_sfr_wdata,
   input wire logic [7:0] o_sfr_rdata,
   input wire logic [7:0] o_guard,
   input wire logic [7:0] o_power_first,
   input wire logic [7:0] o_power_second,
   input wire logic [7:0] o_clock_first,
   input wire logic [7:0] o_watchdog_ctrl,
   input wire logic [7:0] o_port_four,
   input wire logic [7:0] o_port_six,
   input wire logic       o_low_power_mode,
   input wire logic       o_ultra_speed_en,
   input wire logic       o_app_exec_en,
   input wire logic       o_port_reset_scope,
   input wire logic       o_reset_pin_sel,
   input wire logic       o_debug_en
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rst_b);
   wire logic ow = i_sfr_wr && !i_sfr_page_p;
   wire logic dw = i_sfr_wr && i_sfr_page_p && i_sfr_addr == `SFRWG_ADDR_DEVCTL;
   a_port_six_block: assert property (ow && i_sfr_addr == 8'hf8 && o_guard[6] |=> $stable(o_port_six))
      else $error("guarded port six changed");
   a_port_four_block: assert property (ow && i_sfr_addr == 8'he8 && o_guard[5] |=> $stable(o_port_four))
      else $error("guarded port four changed");
   a_watchdog_block: assert property (ow && i_sfr_addr == 8'he1 && o_guard[4] |=> $stable(o_watchdog_ctrl))
      else $error("guarded watchdog changed");
   a_clock_block: assert property (ow && i_sfr_addr == 8'hc7 && o_guard[2] |=> $stable(o_clock_first))
      else $error("guarded clock reg changed");
   a_power_two_block: assert property (ow && i_sfr_addr == 8'h97 && o_guard[1] |=> $stable(o_power_second))
      else $error("guarded power second changed");
   a_power_one_block: assert property (ow && i_sfr_addr == 8'h87 && o_guard[0] |=> $stable(o_power_first))
      else $error("guarded power first changed");
   a_priv_write: assert property (i_sfr_wr && i_sfr_page_p && i_sfr_addr == 8'hf8 |=> o_port_six == $past(i_sfr_wdata))
      else $error("privileged write lost");
   a_six_read: assert property (i_sfr_rd && !i_sfr_page_p && i_sfr_addr == 8'hf8 |=> o_sfr_rdata == $past(o_port_six))
      else $error("port six read wrong");
   a_speed_modes: assert property (dw |=> o_low_power_mode == !$past(i_sfr_wdata[7])
      && o_ultra_speed_en == ($past(i_sfr_wdata[7]) && $past(i_sfr_wdata[5])))
      else $error("speed mode wrong");
   a_flash_pins: assert property (dw |=> o_app_exec_en == !$past(i_sfr_wdata[6])
      && o_reset_pin_sel == $past(i_sfr_wdata[1]) && o_debug_en == $past(i_sfr_wdata[0]))
      else $error("device control bit wrong");
   a_reset_values: assert property (!$past(i_rst_b) |-> o_guard == 8'h00 && o_debug_en && o_reset_pin_sel
      && !o_low_power_mode && !o_ultra_speed_en && o_app_exec_en && o_power_first == 8'h10)
      else $error("reset value wrong");
   a_scope_reset: assert property (!$past(i_rst_b) |-> o_port_six ==
      (($past(o_port_reset_scope) && !$past(i_hard_rst)) ? $past(o_port_six) : 8'hff))
      else $error("port six reset scope wrong");
   c_blocked: cover property (ow && i_sfr_addr == 8'hf8 && o_guard[6]);
   c_soft_keep: cover property (!$past(i_rst_b) && $past(o_port_reset_scope) && !$past(i_hard_rst));
   c_devctl: cover property (dw);
endmodule : sfrwg_checker
bind sfrwg_top sfrwg_checker u_chk (.i_mclk, .i_rst_b, .i_hard_rst, .i_sfr_addr, .i_sfr_page_p, .i_sfr_wr,
   .i_sfr_rd, .i_sfr_wdata, .o_sfr_rdata, .o_guard, .o_power_first, .o_power_second, .o_clock_first,
   .o_watchdog_ctrl, .o_port_four, .o_port_six, .o_low_power_mode, .o_ultra_speed_en, .o_app_exec_en,
   .o_port_reset_scope, .o_reset_pin_sel, .o_debug_en);
`default_nettype wire

/* tb/sfr_write_guard_device_ctrl_tb_top.sv */
// Purpose: self-checking bench of the sfr write guard block
// Assumes: inputs change on the falling edge
// Notes:   table rows first, reset cases after
`timescale 1ns/10ps
`default_nettype none
`include "sfrwg_consts.svh"
module sfr_write_guard_device_ctrl_tb_top;
   typedef struct {logic [7:0] g; logic p; logic [7:0] a, d, e;} sfrwg_row_t;
   logic       i_mclk = 1'b0;
   logic       i_rst_b = 1'b0;
   logic       i_hard_rst = 1'b1;
   logic       i_sfr_page_p = 1'b0;
   logic       i_sfr_wr = 1'b0;
   logic       i_sfr_rd = 1'b0;
   logic [7:0] i_sfr_addr = 8'h00;
   logic [7:0] i_sfr_wdata = 8'h00;
   logic [7:0] o_sfr_rdata, o_guard, o_power_first, o_power_second;
   logic [7:0] o_clock_first, o_watchdog_ctrl, o_port_four, o_port_six;
   logic       o_low_power_mode, o_ultra_speed_en, o_app_exec_en, o_port_reset_scope, o_reset_pin_sel, o_debug_en;
   int         err_count = 0;
   int         n_checks = 0;
   wire logic [7:0] dc = {o_low_power_mode, o_ultra_speed_en, o_app_exec_en, o_port_reset_scope,
                          o_reset_pin_sel, o_debug_en, 2'b00};
   // guard value, page, address, data, expected read back; page 0 stands for any ordinary page
   sfrwg_row_t rows [14] = '{
      '{8'h40, 1'b0, 8'hf8, 8'h12, 8'hff}, '{8'h00, 1'b0, 8'hf8, 8'h12, 8'h12},
      '{8'h20, 1'b0, 8'he8, 8'h34, 8'hff}, '{8'h10, 1'b0, 8'he1, 8'h56, 8'h00},
      '{8'h04, 1'b0, 8'hc7, 8'h78, 8'h00}, '{8'h02, 1'b0, 8'h97, 8'h9a, 8'h00},
      '{8'h01, 1'b0, 8'h87, 8'hbc, 8'h10}, '{8'h7f, 1'b1, 8'hf8, 8'ha5, 8'ha5},
      '{8'h7f, 1'b1, 8'he8, 8'h5a, 8'h5a}, '{8'h7f, 1'b1, 8'he1, 8'hc3, 8'hc3},
      '{8'h7f, 1'b1, 8'hc7, 8'h3c, 8'h3c}, '{8'h7f, 1'b1, 8'h97, 8'h0f, 8'h0f},
      '{8'h7f, 1'b1, 8'h87, 8'hf0, 8'hf0}, '{8'h00, 1'b0, 8'h48, 8'hff, 8'h00}};
   always #4 i_mclk = ~i_mclk;
   sfrwg_top u_dut (.i_mclk, .i_rst_b, .i_hard_rst, .i_sfr_addr, .i_sfr_page_p, .i_sfr_wr, .i_sfr_rd,
      .i_sfr_wdata, .o_sfr_rdata, .o_guard, .o_power_first, .o_power_second, .o_clock_first,
      .o_watchdog_ctrl, .o_port_four, .o_port_six, .o_low_power_mode, .o_ultra_speed_en,
      .o_app_exec_en, .o_port_reset_scope, .o_reset_pin_sel, .o_debug_en);
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      n_checks++;
      if (s !== e) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   // idle cycle after each strobe keeps one assignment per time step
   task automatic wr(input logic p, input logic [7:0] a, input logic [7:0] d);
      i_sfr_page_p = p;
      i_sfr_addr = a;
      i_sfr_wdata = d;
      i_sfr_wr = 1'b1;
      @(negedge i_mclk);
      i_sfr_wr = 1'b0;
      @(negedge i_mclk);
   endtask : wr
   task automatic rd(input logic p, input logic [7:0] a);
      i_sfr_page_p = p;
      i_sfr_addr = a;
      i_sfr_rd = 1'b1;
      @(negedge i_mclk);
      i_sfr_rd = 1'b0;
      @(negedge i_mclk);
   endtask : rd
   task automatic rst(input logic h);
      i_hard_rst = h;
      i_rst_b = 1'b0;
      repeat (2) @(negedge i_mclk);
      i_rst_b = 1'b1;
      @(negedge i_mclk);
   endtask : rst
   task automatic test_done();
      if (err_count == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : test_done
   initial begin
      repeat (8) @(negedge i_mclk);
      i_rst_b = 1'b1;
      @(negedge i_mclk);
      foreach (rows[i]) begin
         wr(1'b1, `SFRWG_ADDR_GUARD, rows[i].g);
         wr(rows[i].p, rows[i].a, rows[i].d);
         rd(rows[i].p, rows[i].a);
         chk("row", o_sfr_rdata, rows[i].e);
      end
      wr(1'b1, `SFRWG_ADDR_DEVCTL, 8'h20);
      chk("dctl", dc, 8'ha0);
      wr(1'b1, `SFRWG_ADDR_DEVCTL, 8'he5);
      rd(1'b1, `SFRWG_ADDR_DEVCTL);
      chk("dctl_rd", o_sfr_rdata, 8'he5);
      chk("dctl", dc, 8'h54);
      wr(1'b1, `SFRWG_ADDR_PORT_SIX, 8'h3c);
      rst(1'b0);
      chk("p6_soft", o_port_six, 8'h3c);
      chk("dctl_rst", dc, 8'h3c);
      chk("guard_rst", o_guard, 8'h00);
      chk("regs_rst", o_power_second | o_clock_first | o_watchdog_ctrl | o_sfr_rdata, 8'h00);
      chk("pf_rst", o_power_first & o_port_four, 8'h10);
      rst(1'b1);
      chk("p6_hard", o_port_six, 8'hff);
      chk("dctl_hard", dc, 8'h2c);
      wr(1'b1, `SFRWG_ADDR_PORT_SIX, 8'h3c);
      rst(1'b0);
      chk("p6_all", o_port_six, 8'hff);
      test_done();
   end
   // the whole run needs a little over a hundred cycles
   initial begin
      repeat (2000) @(posedge i_mclk);
      err_count++;
      test_done();
   end
endmodule : sfr_write_guard_device_ctrl_tb_top
`default_nettype wire
